// *** cmp_ctrl_pkg.sv ***
package cmp_ctrl_pkg;

  // ==========================================================
  // register location
  localparam logic [7:0] CTRL_ADDR      = 8'h9d;
  localparam logic [7:0] CTRL_PAGE      = 8'h00;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  // ==========================================================
  // field positions
  localparam int         EN_BIT         = 7;
  localparam int         OUT_BIT        = 6;
  localparam int         RISE_BIT       = 5;
  localparam int         FALL_BIT       = 4;
  localparam int         HYP_HI         = 3;
  localparam int         HYP_LO         = 2;
  localparam int         HYN_HI         = 1;
  localparam int         HYN_LO         = 0;

  // ==========================================================
  // hysteresis codes
  typedef enum logic [1:0] {
    HYST_OFF   = 2'b00,
    HYST_5MV   = 2'b01,
    HYST_10MV  = 2'b10,
    HYST_20MV  = 2'b11
  } hyst_e;

  localparam logic [4:0] MV_OFF         = 5'h00;
  localparam logic [4:0] MV_5           = 5'h05;
  localparam logic [4:0] MV_10          = 5'h0a;
  localparam logic [4:0] MV_20          = 5'h14;

endpackage

// *** cmp_edge_sync.sv ***
`timescale 1ns/100ps
module cmp_edge_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // asynchronous comparator level
  input  wire logic i_async,
  // synchronised level and edges
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);

  // ==========================================================
  // two-stage synchroniser, then edge detect on stage two only
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  always_comb begin
    nxt_meta = meta_ff;
    nxt_sync = sync_ff;
    nxt_prev = prev_ff;
    if (i_rst) begin
      nxt_meta = 1'b0;
      nxt_sync = 1'b0;
      nxt_prev = 1'b0;
    end else if (i_ce) begin
      nxt_meta = i_async;
      nxt_sync = meta_ff;
      nxt_prev = sync_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
    prev_ff <= nxt_prev;
  end

  assign o_level = sync_ff;
  assign o_rise  = sync_ff & ~prev_ff;
  assign o_fall  = ~sync_ff & prev_ff;

endmodule

// *** comparator1_control.sv ***
`timescale 1ns/100ps
// Behaviour
// - bit 6 reads the comparator result: 1 when the positive input is above the negative input.
// - bit 5 is set on a rising output edge and stays set until software writes it to zero.
// - bit 4 is set on a falling output edge and stays set until software writes it to zero.
// - bits 3:2 select positive hysteresis: off, 5 mV, 10 mV or 20 mV.
// - bits 1:0 select negative hysteresis: off, 5 mV, 10 mV or 20 mV.
// - the register sits at address 0x9d on page 0x00 and resets to all zeros.
module comparator1_control (
  // clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // special-function register access
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_page,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic [7:0]      o_sfr_rdata,
  output logic            o_sfr_hit,
  // analog comparator
  input  wire logic       i_comparator_positive_input_above,
  output logic            o_comparator_enable,
  output logic [4:0]      o_positive_hysteresis_mv,
  output logic [4:0]      o_negative_hysteresis_mv
);

  // ==========================================================
  // helpers
  function automatic logic [4:0] hyst_mv(input logic [1:0] code);
    case (code)
      cmp_ctrl_pkg::HYST_OFF:  hyst_mv = cmp_ctrl_pkg::MV_OFF;
      cmp_ctrl_pkg::HYST_5MV:  hyst_mv = cmp_ctrl_pkg::MV_5;
      cmp_ctrl_pkg::HYST_10MV: hyst_mv = cmp_ctrl_pkg::MV_10;
      cmp_ctrl_pkg::HYST_20MV: hyst_mv = cmp_ctrl_pkg::MV_20;
      default:                 hyst_mv = cmp_ctrl_pkg::MV_OFF;
    endcase
  endfunction

  // ==========================================================
  // comparator input sync
  logic cmp_level;
  logic cmp_rise;
  logic cmp_fall;

  cmp_edge_sync u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_async (i_comparator_positive_input_above),
    .o_level (cmp_level),
    .o_rise  (cmp_rise),
    .o_fall  (cmp_fall)
  );

  // ==========================================================
  // register state
  logic       en_ff;
  logic       out_ff;
  logic       rise_ff;
  logic       fall_ff;
  logic [1:0] hyp_ff;
  logic [1:0] hyn_ff;
  logic [7:0] rdata_ff;
  logic       hit_ff;
  logic [4:0] hyp_mv_ff;
  logic [4:0] hyn_mv_ff;

  logic       nxt_en;
  logic       nxt_out;
  logic       nxt_rise;
  logic       nxt_fall;
  logic [1:0] nxt_hyp;
  logic [1:0] nxt_hyn;
  logic [7:0] nxt_rdata;
  logic       nxt_hit;
  logic [4:0] nxt_hyp_mv;
  logic [4:0] nxt_hyn_mv;
  logic       sel;
  logic       wr;
  logic [7:0] cur;

  assign sel = (i_sfr_addr == cmp_ctrl_pkg::CTRL_ADDR) &&
               (i_sfr_page == cmp_ctrl_pkg::CTRL_PAGE);
  assign wr  = sel & i_sfr_wr;

  always_comb begin
    cur = {en_ff, out_ff, rise_ff, fall_ff, hyp_ff, hyn_ff};
    nxt_en     = en_ff;
    nxt_out    = out_ff;
    nxt_rise   = rise_ff;
    nxt_fall   = fall_ff;
    nxt_hyp    = hyp_ff;
    nxt_hyn    = hyn_ff;
    nxt_rdata  = rdata_ff;
    nxt_hit    = hit_ff;
    nxt_hyp_mv = hyp_mv_ff;
    nxt_hyn_mv = hyn_mv_ff;
    if (i_rst) begin
      {nxt_en, nxt_out, nxt_rise, nxt_fall, nxt_hyp, nxt_hyn} = cmp_ctrl_pkg::CTRL_RESET;
      nxt_rdata  = cmp_ctrl_pkg::CTRL_RESET;
      nxt_hit    = 1'b0;
      nxt_hyp_mv = cmp_ctrl_pkg::MV_OFF;
      nxt_hyn_mv = cmp_ctrl_pkg::MV_OFF;
    end else if (i_ce) begin
      // output flag is read only; writes to bit 6 are dropped
      nxt_out = cmp_level;
      if (wr) begin
        nxt_en   = i_sfr_wdata[cmp_ctrl_pkg::EN_BIT];
        nxt_hyp  = i_sfr_wdata[cmp_ctrl_pkg::HYP_HI:cmp_ctrl_pkg::HYP_LO];
        nxt_hyn  = i_sfr_wdata[cmp_ctrl_pkg::HYN_HI:cmp_ctrl_pkg::HYN_LO];
        nxt_rise = i_sfr_wdata[cmp_ctrl_pkg::RISE_BIT];
        nxt_fall = i_sfr_wdata[cmp_ctrl_pkg::FALL_BIT];
      end
      // an edge in the clearing cycle wins over the clear
      if (cmp_rise) begin
        nxt_rise = 1'b1;
      end
      if (cmp_fall) begin
        nxt_fall = 1'b1;
      end
      nxt_hit   = sel & i_sfr_rd;
      nxt_rdata = (sel & i_sfr_rd) ? cur : rdata_ff;
      nxt_hyp_mv = hyst_mv(nxt_hyp);
      nxt_hyn_mv = hyst_mv(nxt_hyn);
    end
  end

  always_ff @(posedge i_clk) begin
    en_ff     <= nxt_en;
    out_ff    <= nxt_out;
    rise_ff   <= nxt_rise;
    fall_ff   <= nxt_fall;
    hyp_ff    <= nxt_hyp;
    hyn_ff    <= nxt_hyn;
    rdata_ff  <= nxt_rdata;
    hit_ff    <= nxt_hit;
    hyp_mv_ff <= nxt_hyp_mv;
    hyn_mv_ff <= nxt_hyn_mv;
  end

  assign o_sfr_rdata              = rdata_ff;
  assign o_sfr_hit                = hit_ff;
  assign o_comparator_enable      = en_ff;
  assign o_positive_hysteresis_mv = hyp_mv_ff;
  assign o_negative_hysteresis_mv = hyn_mv_ff;

  // ==========================================================
  // checks
  output_tracks_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce |=> out_ff == $past(cmp_level))
    else $error("output flag does not track comparator");
  rise_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cmp_rise) |=> rise_ff)
    else $error("rising edge flag not set");
  rise_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rise_ff && !wr) |=> rise_ff)
    else $error("rising edge flag dropped without write");
  rise_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr && !i_sfr_wdata[cmp_ctrl_pkg::RISE_BIT] && !cmp_rise) |=> !rise_ff)
    else $error("rising edge flag not cleared");
  fall_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && cmp_fall) |=> fall_ff)
    else $error("falling edge flag not set");
  fall_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (fall_ff && !wr) |=> fall_ff)
    else $error("falling edge flag dropped without write");
  fall_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr && !i_sfr_wdata[cmp_ctrl_pkg::FALL_BIT] && !cmp_fall) |=> !fall_ff)
    else $error("falling edge flag not cleared");
  hyp_decode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr &&
     i_sfr_wdata[cmp_ctrl_pkg::HYP_HI:cmp_ctrl_pkg::HYP_LO] == cmp_ctrl_pkg::HYST_20MV)
    |=> hyp_mv_ff == cmp_ctrl_pkg::MV_20)
    else $error("positive hysteresis decode wrong");
  hyp_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr &&
     i_sfr_wdata[cmp_ctrl_pkg::HYP_HI:cmp_ctrl_pkg::HYP_LO] == cmp_ctrl_pkg::HYST_5MV)
    |=> hyp_mv_ff == cmp_ctrl_pkg::MV_5)
    else $error("positive hysteresis low step wrong");
  hyn_decode_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr &&
     i_sfr_wdata[cmp_ctrl_pkg::HYN_HI:cmp_ctrl_pkg::HYN_LO] == cmp_ctrl_pkg::HYST_5MV)
    |=> hyn_mv_ff == cmp_ctrl_pkg::MV_5)
    else $error("negative hysteresis decode wrong");
  hyn_mid_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr &&
     i_sfr_wdata[cmp_ctrl_pkg::HYN_HI:cmp_ctrl_pkg::HYN_LO] == cmp_ctrl_pkg::HYST_10MV)
    |=> hyn_mv_ff == cmp_ctrl_pkg::MV_10)
    else $error("negative hysteresis middle step wrong");
  reset_zero_a: assert property (@(posedge i_clk)
    i_rst |=> (cur == cmp_ctrl_pkg::CTRL_RESET && rdata_ff == cmp_ctrl_pkg::CTRL_RESET))
    else $error("register not zero after reset");
  reset_outputs_a: assert property (@(posedge i_clk)
    i_rst |=> (!hit_ff && hyp_mv_ff == cmp_ctrl_pkg::MV_OFF && hyn_mv_ff == cmp_ctrl_pkg::MV_OFF))
    else $error("outputs not idle after reset");
  enable_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr) |=> en_ff == $past(i_sfr_wdata[cmp_ctrl_pkg::EN_BIT]))
    else $error("enable bit not written");
  read_data_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && sel && i_sfr_rd) |=> (hit_ff && rdata_ff == $past(cur)))
    else $error("read data wrong");
  no_hit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !(sel && i_sfr_rd)) |=> !hit_ff)
    else $error("read answered without a matching read");

  // ==========================================================
  // hold checks: catch a stray update path that the set checks miss
  enable_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_ce && wr) |=> $stable(en_ff))
    else $error("enable bit changed without write");
  hyst_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_ce && wr) |=> ($stable(hyp_mv_ff) && $stable(hyn_mv_ff)))
    else $error("hysteresis changed without write");
  rdata_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_ce && sel && i_sfr_rd) |=> $stable(rdata_ff))
    else $error("read data changed without read");
  out_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> $stable(out_ff))
    else $error("output flag moved while frozen");
  flag_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_ce |=> ($stable(rise_ff) && $stable(fall_ff)))
    else $error("edge flags moved while frozen");

  rise_seen_c: cover property (@(posedge i_clk) disable iff (i_rst) cmp_rise ##1 rise_ff);
  fall_seen_c: cover property (@(posedge i_clk) disable iff (i_rst) cmp_fall ##1 fall_ff);
  clear_c:     cover property (@(posedge i_clk) disable iff (i_rst) rise_ff ##1 !rise_ff);
  set_clear_c: cover property (@(posedge i_clk) disable iff (i_rst) wr && cmp_rise);

endmodule

// *** cmp_input_model.sv ***
`timescale 1ns/100ps
// ==========================================
// analog comparator stand-in
module cmp_input_model (
  // requested level
  input  wire logic i_level_req,
  // comparator result
  output logic      o_above
);
  initial o_above = 1'b0;
  // settles off the clock grid so the sync sees a truly async edge
  always @(i_level_req) o_above <= #7 i_level_req;
endmodule

// *** comparator1_control_tb.sv ***
`timescale 1ns/100ps
module comparator1_control_tb;
  logic       i_clk, i_rst, i_sfr_wr, i_sfr_rd, cmp_req, cmp_above, ce;
  logic [7:0] i_sfr_addr, i_sfr_page, i_sfr_wdata, o_sfr_rdata, d;
  logic       o_sfr_hit, o_comparator_enable;
  logic [4:0] o_positive_hysteresis_mv, o_negative_hysteresis_mv;
  logic [4:0] mv_tbl [4];
  logic [7:0] exp_q [$];
  logic [16:0] seed;
  int         miscompares, samples_checked;
  cmp_input_model u_cmp (.i_level_req(cmp_req), .o_above(cmp_above));
  comparator1_control u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_sfr_addr(i_sfr_addr), .i_sfr_page(i_sfr_page), .i_sfr_wr(i_sfr_wr),
    .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .i_comparator_positive_input_above(cmp_above),
    .o_comparator_enable(o_comparator_enable),
    .o_positive_hysteresis_mv(o_positive_hysteresis_mv),
    .o_negative_hysteresis_mv(o_negative_hysteresis_mv));
  // ==========================================
  // helpers
  function automatic logic [16:0] lfsr(logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic access(logic w, logic r, logic [7:0] a, logic [7:0] p, logic [7:0] v);
    @(posedge i_clk);
    #1;
    i_sfr_wr = w; i_sfr_rd = r; i_sfr_addr = a; i_sfr_page = p; i_sfr_wdata = v;
    @(posedge i_clk);
    #1;
    i_sfr_wr = 1'b0; i_sfr_rd = 1'b0;
  endtask
  task automatic wr(logic [7:0] v);
    access(1'b1, 1'b0, cmp_ctrl_pkg::CTRL_ADDR, cmp_ctrl_pkg::CTRL_PAGE, v);
  endtask
  task automatic rd(logic [7:0] e);
    exp_q.push_back(e);
    access(1'b0, 1'b1, cmp_ctrl_pkg::CTRL_ADDR, cmp_ctrl_pkg::CTRL_PAGE, 8'h00);
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // read monitor: a stray hit with nothing queued is a fault
  always @(negedge i_clk) begin
    if (o_sfr_hit === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("FAIL hit expected none seen one");
      end else check("rdata", o_sfr_rdata, exp_q.pop_front());
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  // ==========================================
  // tests
  initial begin
    mv_tbl = '{cmp_ctrl_pkg::MV_OFF, cmp_ctrl_pkg::MV_5, cmp_ctrl_pkg::MV_10, cmp_ctrl_pkg::MV_20};
    i_rst = 1'b1; i_sfr_wr = 1'b0; i_sfr_rd = 1'b0; cmp_req = 1'b0;
    ce = 1'b1;
    i_sfr_addr = 8'h00; i_sfr_page = 8'h00; i_sfr_wdata = 8'h00; seed = 17'd79897;
    repeat (5) @(posedge i_clk);
    #1 i_rst = 1'b0;
    check("enable", {7'h00, o_comparator_enable}, 8'h00);
    rd(cmp_ctrl_pkg::CTRL_RESET);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = {seed[7], 1'b0, seed[5:4], 2'(i), 2'(3 - i)};
      wr(d);
      check("pos mv", {3'h0, o_positive_hysteresis_mv}, {3'h0, mv_tbl[i]});
      check("neg mv", {3'h0, o_negative_hysteresis_mv}, {3'h0, mv_tbl[3 - i]});
      check("enable", {7'h00, o_comparator_enable}, {7'h00, d[7]});
      rd(d);
    end
    $display("field test done");
    wr(8'h00);
    access(1'b1, 1'b0, 8'h9e, cmp_ctrl_pkg::CTRL_PAGE, 8'hbf);
    access(1'b1, 1'b0, cmp_ctrl_pkg::CTRL_ADDR, 8'h01, 8'hbf);
    access(1'b0, 1'b1, 8'h9c, cmp_ctrl_pkg::CTRL_PAGE, 8'h00);
    rd(8'h00);
    wr(8'hc0);
    rd(8'h80);
    $display("decode test done");
    cmp_req = 1'b1;
    repeat (6) @(posedge i_clk);
    rd(8'he0);
    wr(8'h00);
    rd(8'h40);
    cmp_req = 1'b0;
    repeat (6) @(posedge i_clk);
    rd(8'h10);
    wr(8'h00);
    rd(8'h00);
    $display("edge test done");
    // let the last read pulse drop before freezing, or it would stand
    @(posedge i_clk);
    #1 ce = 1'b0;
    wr(8'h8f);
    check("pos mv", {3'h0, o_positive_hysteresis_mv}, {3'h0, cmp_ctrl_pkg::MV_OFF});
    check("enable", {7'h00, o_comparator_enable}, 8'h00);
    ce = 1'b1;
    rd(8'h00);
    wr(8'h8f);
    check("enable", {7'h00, o_comparator_enable}, 8'h01);
    check("neg mv", {3'h0, o_negative_hysteresis_mv}, {3'h0, cmp_ctrl_pkg::MV_20});
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    check("enable", {7'h00, o_comparator_enable}, 8'h00);
    check("pos mv", {3'h0, o_positive_hysteresis_mv}, {3'h0, cmp_ctrl_pkg::MV_OFF});
    check("neg mv", {3'h0, o_negative_hysteresis_mv}, {3'h0, cmp_ctrl_pkg::MV_OFF});
    rd(cmp_ctrl_pkg::CTRL_RESET);
    $display("hold and restart test done");
    repeat (3) @(posedge i_clk);
    report_and_stop();
  end
endmodule
